// *** inc/pecd_defines.svh ***
`ifndef PECD_DEFINES_SVH
`define PECD_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define PECD_OFF_A_RISE 6'h00
`define PECD_OFF_A_FALL 6'h04
`define PECD_OFF_A_FLAGS 6'h08
`define PECD_OFF_B_RISE 6'h0c
`define PECD_OFF_B_FALL 6'h10
`define PECD_OFF_B_FLAGS 6'h14
`define PECD_OFF_C_RISE 6'h18
`define PECD_OFF_C_FALL 6'h1c
`define PECD_OFF_C_FLAGS 6'h20
`define PECD_OFF_CTRL 6'h24
`define PECD_OFF_IRQ_STATUS 6'h28
`define PECD_OFF_IRQ_MASK 6'h2c
`define PECD_OFF_STATE 6'h30

// ---------------------------------------------------------------
// Implemented bits per group
// ---------------------------------------------------------------
`define PECD_MASK_A 8'h3f
`define PECD_MASK_B 8'hf0
`define PECD_MASK_C_LOW 8'h3f
`define PECD_MASK_C_HIGH 8'hc0
`define PECD_MASK_NONE 8'h00

// ---------------------------------------------------------------
// Fields, reset values and counts
// ---------------------------------------------------------------
`define PECD_RST_BYTE 8'h00
`define PECD_RST_EVT 3'h0
`define PECD_RST_WORD 32'h0000_0000
`define PECD_CTRL_CIE_BIT 0
`define PECD_STATE_SUMMARY_BIT 0
`define PECD_STATE_LARGE_BIT 1
`define PECD_SYNC_PRIME 2'h3

`endif

// *** inc/pecd_pkg.sv ***
package pecd_pkg;

	typedef logic [7:0] pecd_byte_t;
	typedef logic [5:0] pecd_addr_t;
	typedef logic [31:0] pecd_word_t;
	typedef logic [3:0] pecd_be_t;
	typedef logic [2:0] pecd_evt_t;
	typedef logic [23:0] pecd_pins_t;

endpackage

// *** design/pecd_pin_edge.sv ***
`timescale 1ns/1ps
`include "pecd_defines.svh"

module pecd_pin_edge #(
	parameter int WIDTH = 24
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Raw pins
	input wire logic [WIDTH-1:0] pin_in,
	// Edge pulses
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	import pecd_pkg::*;

	// ---------------------------------------------------------------
	// Parameter check
	// ---------------------------------------------------------------
	if (WIDTH < 1) begin : g_bad_width
		$error("pecd_pin_edge: WIDTH must be at least one");
	end

	// ---------------------------------------------------------------
	// Start-up priming, no edge until the synchroniser holds real data
	// ---------------------------------------------------------------
	logic [1:0] prime_cnt;
	logic [1:0] next_prime_cnt;
	logic primed;

	assign primed = (prime_cnt == `PECD_SYNC_PRIME);

	always_comb begin
		next_prime_cnt = primed ? prime_cnt : prime_cnt + 2'h1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prime_cnt <= 2'h0;
		end else begin
			prime_cnt <= next_prime_cnt;
		end
	end

	// ---------------------------------------------------------------
	// Per-pin synchroniser and edge detector
	// ---------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_pin
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic rise_q;
		logic fall_q;
		logic next_level;
		logic next_rise;
		logic next_fall;

		always_comb begin
			next_level = level;
			next_rise = 1'b0;
			next_fall = 1'b0;
			// Reference level follows the pin while priming, so no false edge follows reset
			if (!primed) begin
				next_level = s2;
			end else if (s2 == s3) begin
				next_level = s3;
				next_rise = primed & s3 & ~level;
				next_fall = primed & ~s3 & level;
			end
		end

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				s1 <= 1'b0;
				s2 <= 1'b0;
				s3 <= 1'b0;
				level <= 1'b0;
				rise_q <= 1'b0;
				fall_q <= 1'b0;
			end else begin
				s1 <= pin_in[i];
				s2 <= s1;
				s3 <= s2;
				level <= next_level;
				rise_q <= next_rise;
				fall_q <= next_fall;
			end
		end

		assign rise[i] = rise_q;
		assign fall[i] = fall_q;

		rise_one_cycle_a: assert property (@(posedge clk) disable iff (sys_rst) rise_q |=> !rise_q)
			else $error("rise pulse lasted more than one cycle");
		fall_one_cycle_a: assert property (@(posedge clk) disable iff (sys_rst) fall_q |=> !fall_q)
			else $error("fall pulse lasted more than one cycle");
	end

endmodule // pecd_pin_edge

// *** design/pecd_top.sv ***
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`include "pecd_defines.svh"

module pecd_top #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Port pins
	input wire pecd_pkg::pecd_byte_t first_group_pin,
	input wire pecd_pkg::pecd_byte_t second_group_pin,
	input wire pecd_pkg::pecd_byte_t third_group_pin,
	// Avalon-MM slave
	input wire pecd_pkg::pecd_addr_t avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire pecd_pkg::pecd_word_t avs_writedata,
	input wire pecd_pkg::pecd_be_t avs_byteenable,
	output pecd_pkg::pecd_word_t avs_readdata,
	output logic avs_waitrequest,
	// CPU side
	output logic summary_change_flag,
	output logic change_irq,
	output logic wake_request,
	output logic irq
);
	import pecd_pkg::*;

	// ---------------------------------------------------------------
	// Implemented bit masks per variant
	// ---------------------------------------------------------------
	localparam pecd_byte_t MASK_A = `PECD_MASK_A;
	localparam pecd_byte_t MASK_B = LARGE_VARIANT ? `PECD_MASK_B : `PECD_MASK_NONE;
	localparam pecd_byte_t MASK_C = LARGE_VARIANT ? (`PECD_MASK_C_LOW | `PECD_MASK_C_HIGH) : `PECD_MASK_C_LOW;

	// ---------------------------------------------------------------
	// Edge detection
	// ---------------------------------------------------------------
	pecd_pins_t rise_all;
	pecd_pins_t fall_all;

	pecd_pin_edge #(
		.WIDTH(24)
	) u_edge (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in({third_group_pin, second_group_pin, first_group_pin}),
		.rise(rise_all),
		.fall(fall_all)
	);

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	pecd_byte_t first_group_rise_enable;
	pecd_byte_t first_group_fall_enable;
	pecd_byte_t first_group_change_flag;
	pecd_byte_t second_group_rise_enable;
	pecd_byte_t second_group_fall_enable;
	pecd_byte_t second_group_change_flag;
	pecd_byte_t third_group_rise_enable;
	pecd_byte_t third_group_fall_enable;
	pecd_byte_t third_group_change_flag;
	logic change_interrupt_enable;
	pecd_evt_t irq_status;
	pecd_evt_t irq_mask;

	pecd_byte_t next_a_rise;
	pecd_byte_t next_a_fall;
	pecd_byte_t next_a_flag;
	pecd_byte_t next_b_rise;
	pecd_byte_t next_b_fall;
	pecd_byte_t next_b_flag;
	pecd_byte_t next_c_rise;
	pecd_byte_t next_c_fall;
	pecd_byte_t next_c_flag;
	logic next_cie;
	pecd_evt_t next_irq_status;
	pecd_evt_t next_irq_mask;

	// ---------------------------------------------------------------
	// Bus handshake state
	// ---------------------------------------------------------------
	logic next_waitrequest;
	pecd_word_t next_readdata;
	pecd_evt_t status_seen;
	pecd_evt_t next_status_seen;
	logic next_summary;
	logic next_change_irq;
	logic next_irq;

	logic accept;
	logic wr_en;
	logic rd_en;
	pecd_byte_t wbyte;
	pecd_byte_t hit_a;
	pecd_byte_t hit_b;
	pecd_byte_t hit_c;
	pecd_byte_t rhit_a;
	pecd_byte_t rhit_b;
	pecd_byte_t rhit_c;
	pecd_byte_t fhit_a;
	pecd_byte_t fhit_b;
	pecd_byte_t fhit_c;
	pecd_evt_t events;
	pecd_word_t read_mux;

	assign accept = (avs_read | avs_write) & ~avs_waitrequest;
	assign wr_en = avs_write & ~avs_waitrequest & avs_byteenable[0];
	assign rd_en = avs_read & ~avs_waitrequest;
	assign wbyte = avs_writedata[7:0];

	// ---------------------------------------------------------------
	// Enabled edge hits
	// ---------------------------------------------------------------
	always_comb begin
		rhit_a = rise_all[7:0] & first_group_rise_enable & MASK_A;
		fhit_a = fall_all[7:0] & first_group_fall_enable & MASK_A;
		rhit_b = rise_all[15:8] & second_group_rise_enable & MASK_B;
		fhit_b = fall_all[15:8] & second_group_fall_enable & MASK_B;
		rhit_c = rise_all[23:16] & third_group_rise_enable & MASK_C;
		fhit_c = fall_all[23:16] & third_group_fall_enable & MASK_C;
		hit_a = rhit_a | fhit_a;
		hit_b = rhit_b | fhit_b;
		hit_c = rhit_c | fhit_c;
		events = {|hit_c, |hit_b, |hit_a};
	end

	// ---------------------------------------------------------------
	// Register next values
	// ---------------------------------------------------------------
	always_comb begin
		next_a_rise = first_group_rise_enable;
		next_a_fall = first_group_fall_enable;
		next_a_flag = first_group_change_flag;
		next_b_rise = second_group_rise_enable;
		next_b_fall = second_group_fall_enable;
		next_b_flag = second_group_change_flag;
		next_c_rise = third_group_rise_enable;
		next_c_fall = third_group_fall_enable;
		next_c_flag = third_group_change_flag;
		next_cie = change_interrupt_enable;
		next_irq_mask = irq_mask;
		next_irq_status = irq_status;
		if (wr_en) begin
			unique case (avs_address)
				`PECD_OFF_A_RISE: next_a_rise = wbyte & MASK_A;
				`PECD_OFF_A_FALL: next_a_fall = wbyte & MASK_A;
				`PECD_OFF_A_FLAGS: next_a_flag = wbyte & MASK_A;
				`PECD_OFF_B_RISE: next_b_rise = wbyte & MASK_B;
				`PECD_OFF_B_FALL: next_b_fall = wbyte & MASK_B;
				`PECD_OFF_B_FLAGS: next_b_flag = wbyte & MASK_B;
				`PECD_OFF_C_RISE: next_c_rise = wbyte & MASK_C;
				`PECD_OFF_C_FALL: next_c_fall = wbyte & MASK_C;
				`PECD_OFF_C_FLAGS: next_c_flag = wbyte & MASK_C;
				`PECD_OFF_CTRL: next_cie = wbyte[`PECD_CTRL_CIE_BIT];
				`PECD_OFF_IRQ_MASK: next_irq_mask = wbyte[2:0];
				default: ;
			endcase
		end
		// Read of the status register clears only what it returned
		if (rd_en && avs_address == `PECD_OFF_IRQ_STATUS) begin
			next_irq_status = irq_status & ~status_seen;
		end
		// Hardware set wins over any clear in the same cycle
		next_a_flag = next_a_flag | hit_a;
		next_b_flag = next_b_flag | hit_b;
		next_c_flag = next_c_flag | hit_c;
		next_irq_status = next_irq_status | events;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			first_group_rise_enable <= `PECD_RST_BYTE;
			first_group_fall_enable <= `PECD_RST_BYTE;
			first_group_change_flag <= `PECD_RST_BYTE;
			second_group_rise_enable <= `PECD_RST_BYTE;
			second_group_fall_enable <= `PECD_RST_BYTE;
			second_group_change_flag <= `PECD_RST_BYTE;
			third_group_rise_enable <= `PECD_RST_BYTE;
			third_group_fall_enable <= `PECD_RST_BYTE;
			third_group_change_flag <= `PECD_RST_BYTE;
			change_interrupt_enable <= 1'b0;
			irq_status <= `PECD_RST_EVT;
			irq_mask <= `PECD_RST_EVT;
		end else begin
			first_group_rise_enable <= next_a_rise;
			first_group_fall_enable <= next_a_fall;
			first_group_change_flag <= next_a_flag;
			second_group_rise_enable <= next_b_rise;
			second_group_fall_enable <= next_b_fall;
			second_group_change_flag <= next_b_flag;
			third_group_rise_enable <= next_c_rise;
			third_group_fall_enable <= next_c_fall;
			third_group_change_flag <= next_c_flag;
			change_interrupt_enable <= next_cie;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
		end
	end

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	always_comb begin
		read_mux = `PECD_RST_WORD;
		unique case (avs_address)
			`PECD_OFF_A_RISE: read_mux[7:0] = first_group_rise_enable;
			`PECD_OFF_A_FALL: read_mux[7:0] = first_group_fall_enable;
			`PECD_OFF_A_FLAGS: read_mux[7:0] = first_group_change_flag;
			`PECD_OFF_B_RISE: read_mux[7:0] = second_group_rise_enable;
			`PECD_OFF_B_FALL: read_mux[7:0] = second_group_fall_enable;
			`PECD_OFF_B_FLAGS: read_mux[7:0] = second_group_change_flag;
			`PECD_OFF_C_RISE: read_mux[7:0] = third_group_rise_enable;
			`PECD_OFF_C_FALL: read_mux[7:0] = third_group_fall_enable;
			`PECD_OFF_C_FLAGS: read_mux[7:0] = third_group_change_flag;
			`PECD_OFF_CTRL: read_mux[`PECD_CTRL_CIE_BIT] = change_interrupt_enable;
			`PECD_OFF_IRQ_STATUS: read_mux[2:0] = irq_status;
			`PECD_OFF_IRQ_MASK: read_mux[2:0] = irq_mask;
			`PECD_OFF_STATE: begin
				read_mux[`PECD_STATE_SUMMARY_BIT] = summary_change_flag;
				read_mux[`PECD_STATE_LARGE_BIT] = LARGE_VARIANT;
			end
			default: ;
		endcase
	end

	// ---------------------------------------------------------------
	// Bus handshake and outputs
	// ---------------------------------------------------------------
	always_comb begin
		next_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
		next_readdata = avs_readdata;
		next_status_seen = status_seen;
		if (avs_read && avs_waitrequest) begin
			next_readdata = read_mux;
			next_status_seen = (avs_address == `PECD_OFF_IRQ_STATUS) ? irq_status : `PECD_RST_EVT;
		end
		next_summary = |{next_a_flag, next_b_flag, next_c_flag};
		next_change_irq = next_cie & next_summary;
		next_irq = |(next_irq_status & next_irq_mask);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= `PECD_RST_WORD;
			status_seen <= `PECD_RST_EVT;
			summary_change_flag <= 1'b0;
			change_irq <= 1'b0;
			wake_request <= 1'b0;
			irq <= 1'b0;
		end else begin
			avs_waitrequest <= next_waitrequest;
			avs_readdata <= next_readdata;
			status_seen <= next_status_seen;
			summary_change_flag <= next_summary;
			change_irq <= next_change_irq;
			wake_request <= next_change_irq;
			irq <= next_irq;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	pecd_pins_t flags_all;
	pecd_pins_t rhit_all;
	pecd_pins_t fhit_all;
	logic flag_wr;

	assign flags_all = {third_group_change_flag, second_group_change_flag, first_group_change_flag};
	assign rhit_all = {rhit_c, rhit_b, rhit_a};
	assign fhit_all = {fhit_c, fhit_b, fhit_a};
	assign flag_wr = wr_en && (avs_address == `PECD_OFF_A_FLAGS || avs_address == `PECD_OFF_B_FLAGS
		|| avs_address == `PECD_OFF_C_FLAGS);

	sequence bus_request_s;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence

	sequence bus_answer_s;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	rise_sets_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		(rhit_all != 24'h0) |=> ((flags_all & $past(rhit_all)) == $past(rhit_all)))
		else $error("enabled rising edge did not set its flag");

	fall_sets_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		(fhit_all != 24'h0) |=> ((flags_all & $past(fhit_all)) == $past(fhit_all)))
		else $error("enabled falling edge did not set its flag");

	no_stray_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		!flag_wr |=> ((flags_all & ~$past(flags_all) & ~$past(rhit_all | fhit_all)) == 24'h0))
		else $error("flag set without an enabled edge");

	flag_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
		!flag_wr |=> (($past(flags_all) & ~flags_all) == 24'h0))
		else $error("flag cleared without a write");

	flag_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		(wr_en && avs_address == `PECD_OFF_A_FLAGS && wbyte == 8'h00 && hit_a == 8'h00)
		|=> (first_group_change_flag == 8'h00))
		else $error("writing zero did not clear the flags");

	summary_or_a: assert property (@(posedge clk) disable iff (sys_rst)
		summary_change_flag == (flags_all != 24'h0))
		else $error("summary flag differs from OR of pin flags");

	low_bits_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		(second_group_rise_enable[3:0] == 4'h0) && (second_group_fall_enable[3:0] == 4'h0)
		&& (second_group_change_flag[3:0] == 4'h0))
		else $error("unimplemented second group bits not zero");

	small_variant_a: assert property (@(posedge clk) disable iff (sys_rst)
		!LARGE_VARIANT |-> (second_group_change_flag == 8'h00 && third_group_change_flag[7:6] == 2'h0))
		else $error("absent bits hold a value on small variant");

	reset_clears_a: assert property (@(posedge clk)
		sys_rst |=> (flags_all == 24'h0 && first_group_rise_enable == 8'h00 && third_group_fall_enable == 8'h00))
		else $error("reset did not clear enables and flags");

	edge_on_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		(flag_wr && (rhit_all | fhit_all) != 24'h0)
		|=> ((flags_all & $past(rhit_all | fhit_all)) == $past(rhit_all | fhit_all)))
		else $error("edge lost during flag write");

	wake_follows_a: assert property (@(posedge clk) disable iff (sys_rst)
		wake_request == (change_interrupt_enable && summary_change_flag))
		else $error("wake request does not match enable and summary");

	bus_one_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
		bus_request_s |=> bus_answer_s)
		else $error("bus answer not given after one wait cycle");

endmodule // pecd_top

// *** bench/pecd_pin_model.sv ***
`timescale 1ns/1ps
module pecd_pin_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Levels asked for
	input wire pecd_pkg::pecd_byte_t want_a,
	input wire pecd_pkg::pecd_byte_t want_b,
	input wire pecd_pkg::pecd_byte_t want_c,
	// Port pins
	output pecd_pkg::pecd_byte_t first_group_pin = 8'h00,
	output pecd_pkg::pecd_byte_t second_group_pin = 8'h00,
	output pecd_pkg::pecd_byte_t third_group_pin = 8'h00,
	// CPU side
	input wire logic wake_request,
	output logic [7:0] wake_count
);
	import pecd_pkg::*;
	logic wake_seen;
	// Pins move just after an edge and then hold steady
	always @(posedge clk) begin
		first_group_pin <= want_a;
		second_group_pin <= want_b;
		third_group_pin <= want_c;
	end
	// CPU counts each wake request once, on its rise
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wake_seen <= 1'b0;
			wake_count <= 8'h00;
		end else begin
			wake_seen <= wake_request;
			if (wake_request && !wake_seen) begin
				wake_count <= wake_count + 8'h01;
			end
		end
	end
endmodule // pecd_pin_model

// *** bench/pecd_top_tb.sv ***
`timescale 1ns/1ps
`include "pecd_defines.svh"
module pecd_top_tb;
	import pecd_pkg::*;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	pecd_addr_t avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	pecd_word_t avs_writedata = 32'h0000_0000;
	pecd_be_t avs_byteenable = 4'hf;
	pecd_word_t avs_readdata;
	pecd_word_t small_readdata;
	pecd_word_t small_seen = 32'h0000_0000;
	logic avs_waitrequest;
	logic summary_change_flag;
	logic change_irq;
	logic wake_request;
	logic irq;
	pecd_byte_t first_group_pin;
	pecd_byte_t second_group_pin;
	pecd_byte_t third_group_pin;
	pecd_byte_t want_a = 8'h00;
	pecd_byte_t want_b = 8'h00;
	pecd_byte_t want_c = 8'h00;
	logic [7:0] wake_count;
	int n_errors = 0;
	int n_compared = 0;
	int n_cycles = 0;

	always #25 clk = ~clk;

	pecd_top #(.LARGE_VARIANT(1'b1)) i_pecd_top (.clk(clk), .sys_rst(sys_rst),
		.first_group_pin(first_group_pin), .second_group_pin(second_group_pin),
		.third_group_pin(third_group_pin), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.summary_change_flag(summary_change_flag), .change_irq(change_irq),
		.wake_request(wake_request), .irq(irq));

	pecd_top #(.LARGE_VARIANT(1'b0)) i_pecd_top_small (.clk(clk), .sys_rst(sys_rst),
		.first_group_pin(first_group_pin), .second_group_pin(second_group_pin),
		.third_group_pin(third_group_pin), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(small_readdata), .avs_waitrequest(), .summary_change_flag(), .change_irq(),
		.wake_request(), .irq());

	pecd_pin_model i_pecd_pin_model (.clk(clk), .sys_rst(sys_rst), .want_a(want_a), .want_b(want_b),
		.want_c(want_c), .first_group_pin(first_group_pin), .second_group_pin(second_group_pin),
		.third_group_pin(third_group_pin), .wake_request(wake_request), .wake_count(wake_count));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_word(input string what, input pecd_word_t exp, input pecd_word_t got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic bus_write(input pecd_addr_t a, input pecd_byte_t d, input pecd_be_t be);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_byteenable <= be;
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input pecd_addr_t a, input pecd_byte_t d);
		bus_write(a, d, 4'hf);
	endtask

	task automatic rd_chk(input string what, input pecd_addr_t a, input pecd_word_t exp);
		pecd_word_t d;
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		small_seen = small_readdata;
		avs_read <= 1'b0;
		@(posedge clk);
		chk_word(what, exp, d);
	endtask

	task automatic drive(input pecd_byte_t a, input pecd_byte_t b, input pecd_byte_t c);
		want_a <= a;
		want_b <= b;
		want_c <= c;
		repeat (8) @(posedge clk);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 12; i++) begin
			rd_chk("reset value", pecd_addr_t'(i * 4), `PECD_RST_WORD);
		end
		rd_chk("state", `PECD_OFF_STATE, 32'h0000_0002);
		rd_chk("unmapped", 6'h3c, 32'h0000_0000);
		chk_bit("summary", 1'b0, summary_change_flag);
		chk_bit("irq", 1'b0, irq);
	endtask

	task automatic t_impl();
		pecd_byte_t m [9];
		pecd_byte_t ms [9];
		m = '{8'h3f, 8'h3f, 8'h3f, 8'hf0, 8'hf0, 8'hf0, 8'hff, 8'hff, 8'hff};
		ms = '{8'h3f, 8'h3f, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h3f, 8'h3f};
		for (int i = 0; i < 9; i++) begin
			wr(pecd_addr_t'(i * 4), 8'hff);
			rd_chk("implemented bits", pecd_addr_t'(i * 4), {24'h00_0000, m[i]});
			chk_word("small variant bits", {24'h00_0000, ms[i]}, small_seen);
		end
		bus_write(`PECD_OFF_B_RISE, 8'h00, 4'he);
		rd_chk("lane off", `PECD_OFF_B_RISE, 32'h0000_00f0);
		chk_bit("summary by write", 1'b1, summary_change_flag);
		for (int i = 0; i < 9; i++) begin
			wr(pecd_addr_t'(i * 4), 8'h00);
		end
		wr(6'h34, 8'hff);
		rd_chk("unmapped write", 6'h34, 32'h0000_0000);
		wr(`PECD_OFF_STATE, 8'hff);
		rd_chk("state read only", `PECD_OFF_STATE, 32'h0000_0002);
		chk_word("small state", 32'h0000_0000, small_seen);
		chk_bit("summary cleared", 1'b0, summary_change_flag);
	endtask

	task automatic t_edges();
		wr(`PECD_OFF_A_RISE, 8'h01);
		wr(`PECD_OFF_A_FALL, 8'h02);
		wr(`PECD_OFF_B_RISE, 8'h10);
		wr(`PECD_OFF_B_FALL, 8'h20);
		wr(`PECD_OFF_C_RISE, 8'h0f);
		wr(`PECD_OFF_C_FALL, 8'hf0);
		drive(8'hff, 8'hff, 8'hff);
		rd_chk("first rise", `PECD_OFF_A_FLAGS, 32'h0000_0001);
		rd_chk("second rise", `PECD_OFF_B_FLAGS, 32'h0000_0010);
		rd_chk("third rise", `PECD_OFF_C_FLAGS, 32'h0000_000f);
		chk_bit("irq gated", 1'b0, change_irq);
		chk_bit("summary set", 1'b1, summary_change_flag);
		wr(`PECD_OFF_A_FLAGS, 8'h00);
		wr(`PECD_OFF_B_FLAGS, 8'h00);
		wr(`PECD_OFF_C_FLAGS, 8'h00);
		drive(8'h00, 8'h00, 8'h00);
		rd_chk("first fall", `PECD_OFF_A_FLAGS, 32'h0000_0002);
		rd_chk("second fall", `PECD_OFF_B_FLAGS, 32'h0000_0020);
		rd_chk("third fall", `PECD_OFF_C_FLAGS, 32'h0000_00f0);
		chk_bit("irq unmasked off", 1'b0, irq);
		wr(`PECD_OFF_CTRL, 8'h01);
		repeat (2) @(posedge clk);
		chk_bit("change irq", 1'b1, change_irq);
		chk_bit("wake", 1'b1, wake_request);
		chk_word("wake count", 32'h0000_0001, {24'h00_0000, wake_count});
		wr(`PECD_OFF_A_FLAGS, 8'h00);
		wr(`PECD_OFF_B_FLAGS, 8'h00);
		rd_chk("third kept", `PECD_OFF_C_FLAGS, 32'h0000_00f0);
		chk_bit("summary or", 1'b1, summary_change_flag);
		wr(`PECD_OFF_C_FLAGS, 8'h00);
		repeat (2) @(posedge clk);
		chk_bit("summary none", 1'b0, summary_change_flag);
		chk_bit("wake off", 1'b0, wake_request);
		wr(`PECD_OFF_IRQ_MASK, 8'h07);
		repeat (2) @(posedge clk);
		chk_bit("irq raised", 1'b1, irq);
		rd_chk("irq status", `PECD_OFF_IRQ_STATUS, 32'h0000_0007);
		repeat (2) @(posedge clk);
		chk_bit("irq cleared", 1'b0, irq);
		rd_chk("status read clear", `PECD_OFF_IRQ_STATUS, 32'h0000_0000);
	endtask

	task automatic t_race();
		@(posedge clk);
		want_c <= 8'h01;
		repeat (4) @(posedge clk);
		wr(`PECD_OFF_C_FLAGS, 8'h00);
		rd_chk("edge during clear", `PECD_OFF_C_FLAGS, 32'h0000_0001);
		wr(`PECD_OFF_C_FLAGS, 8'h00);
		rd_chk("flag cleared", `PECD_OFF_C_FLAGS, 32'h0000_0000);
	endtask

	// ---------------------------------------------------------------
	// Sequence and timeout
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		n_cycles++;
		if (n_cycles == 5000) begin
			n_errors++;
			print_verdict();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_impl();
		t_edges();
		t_race();
		sys_rst <= 1'b1;
		want_c <= 8'h00;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset();
		print_verdict();
	end
endmodule // pecd_top_tb
